// ### src/cmp_regs_pkg.sv
// Constants shared by the comparator register bank and its helpers.
// Assumes a single 100 MHz system clock and a plain strobe-style register port.
//
// Functional notes
// (R1) Bit 0 of the masked status register reads the comparator interrupt state gated by enable bit 0.
// (R2) Writing a one to bit 0 of the masked status register clears the pending interrupt; a zero does nothing.
// (R3) Raw status bit 0 is set by every comparator interrupt event whatever the enable holds.
// (R4) The interrupt reaches the processor only while enable bit 0 is one.
// (R5) Ladder power bit 9 leaves the ladder unpowered at zero and ties it to the analog supply at one.
// (R6) Ladder power comes out of reset as zero so an unused reference draws least power.
// (R7) Ladder range bit 8 picks a 32 R ladder at zero and a 24 R ladder at one.
// (R8) The tap field in bits 3:0 drives the analog multiplexer select for the reference tap.
// (R9) Bit 1 of the comparator output status register returns the present comparator output level.
// (R10) Software treats reserved bits as indeterminate and writes them back unchanged.
// (R11) Events follow the two-bit sense select: 00 level, 01 falling edge, 10 rising edge.
// (R12) Raw status stays set until cleared through the masked status register; writes to read-only registers do nothing.
// (R13) The interrupt line is high exactly while the masked status bit reads one.
`default_nettype none

package cmp_regs_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_MASKED_STATUS = 8'h00;
  localparam logic [7:0] OFF_RAW_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFF_LADDER_CTRL = 8'h10;
  localparam logic [7:0] OFF_OUTPUT_STATUS = 8'h20;
  localparam logic [7:0] OFF_SENSE_CTRL = 8'h30;

  // ==========================================================
  // Field positions
  localparam int IRQ_BIT = 0;
  localparam int LADDER_POWER_BIT = 9;
  localparam int LADDER_RANGE_BIT = 8;
  localparam int TAP_LSB = 0;
  localparam int TAP_W = 4;
  localparam int OUTPUT_LEVEL_BIT = 1;
  localparam int SENSE_LSB = 2;
  localparam int SENSE_W = 2;
  localparam int LEVEL_VALUE_BIT = 4;

  // ==========================================================
  // Reset values and sense encodings
  localparam logic [TAP_W-1:0] TAP_RESET = 4'h0;
  localparam logic [SENSE_W-1:0] SENSE_LEVEL = 2'h0;
  localparam logic [SENSE_W-1:0] SENSE_FALLING = 2'h1;
  localparam logic [SENSE_W-1:0] SENSE_RISING = 2'h2;
  localparam logic [SENSE_W-1:0] SENSE_EITHER = 2'h3;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

`default_nettype wire

// ### src/cmp_sense_if.sv
// Interface between the register bank and its interrupt sense detector.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none

interface cmp_sense_if;
  import cmp_regs_pkg::*;
  logic level;
  logic [SENSE_W-1:0] sense_mode;
  logic level_value;
  logic event_pulse;

  // ==========================================================
  // Owner drives configuration, detector answers with events
  modport owner (output level, output sense_mode, output level_value, input event_pulse);
  modport detector (input level, input sense_mode, input level_value, output event_pulse);
endinterface

`default_nettype wire

// ### src/cmp_pin_sync.sv
// Three-flop synchroniser for the asynchronous comparator output.
// Assumes the input may change at any time relative to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module cmp_pin_sync (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic async_in,
  output logic level
);
  logic s1_ff, s2_ff, s3_ff, level_ff;
  wire agree = (s2_ff == s3_ff);

  // ==========================================================
  // First stage feeds only the second; a change counts once two later stages agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree) begin
        level_ff <= s3_ff;
      end
    end
  end
  assign level = level_ff;

  chk_sync_agree_change: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(level_ff) |-> $past(s2_ff) == $past(s3_ff))
    else $error("synchronised level changed without agreement");
endmodule // cmp_pin_sync

`default_nettype wire

// ### src/cmp_event_sense.sv
// Turns the synchronised comparator level into interrupt events.
// Assumes level is already in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none

module cmp_event_sense
  import cmp_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  cmp_sense_if.detector sif
);
  logic prev_ff, event_ff;
  wire rise = sif.level & ~prev_ff;
  wire fall = ~sif.level & prev_ff;
  wire level_hit = (sif.level == sif.level_value);
  logic nxt_event;

  // ==========================================================
  // Sense select; 11 taken as either edge
  always_comb begin
    unique case (sif.sense_mode)
      SENSE_LEVEL: nxt_event = level_hit; // R11
      SENSE_FALLING: nxt_event = fall; // R11
      SENSE_RISING: nxt_event = rise; // R11
      SENSE_EITHER: nxt_event = rise | fall;
    endcase
  end

  // Previous level starts low, so a high level after reset reads as a rise
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prev_ff <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      prev_ff <= sif.level;
      event_ff <= nxt_event;
    end
  end
  assign sif.event_pulse = event_ff;

  chk_rising_edge_event: assert property (@(posedge sys_clk) disable iff (reset)
    (sif.sense_mode == SENSE_RISING && rise) |=> event_ff) // R11
    else $error("rising edge did not raise an event");
  chk_falling_no_rise: assert property (@(posedge sys_clk) disable iff (reset)
    (sif.sense_mode == SENSE_FALLING && !fall) |=> !event_ff) // R11
    else $error("falling sense fired without a falling edge");
endmodule // cmp_event_sense

`default_nettype wire

// ### src/cmp_register_bank.sv
// Register bank for one analog comparator: interrupt status, enable,
// reference ladder control, sense select and output level readback.
// Assumes a strobe-style register master on sys_clk and an asynchronous
// comparator output arriving from the analog domain.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module cmp_register_bank
  import cmp_regs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic comparator_out,
  output logic irq,
  output logic ladder_power,
  output logic ladder_range_select,
  output logic [TAP_W-1:0] ladder_tap
);

  // ==========================================================
  // Elaboration check
  generate
    if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr
      $error("ADDR_W must be 6 to 8 to decode the register map");
    end
  endgenerate

  // ==========================================================
  // State
  logic raw_ff, nxt_raw;
  logic enable_ff;
  logic power_ff, range_ff;
  logic [TAP_W-1:0] tap_ff;
  logic [SENSE_W-1:0] sense_ff;
  logic level_value_ff;
  logic irq_ff, nxt_irq;
  logic [31:0] rdata_ff;
  logic cmp_level;
  logic [7:0] addr8;

  cmp_sense_if sif ();

  // ==========================================================
  // Comparator output path
  cmp_pin_sync u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(comparator_out),
    .level(cmp_level)
  );

  cmp_event_sense u_sense (
    .sys_clk(sys_clk),
    .reset(reset),
    .sif(sif)
  );

  // Configuration out to the detector
  assign sif.level = cmp_level;
  assign sif.sense_mode = sense_ff;
  assign sif.level_value = level_value_ff;

  // ==========================================================
  // Address decode
  assign addr8 = 8'(reg_addr);
  wire sel_mis = (addr8 == OFF_MASKED_STATUS);
  wire sel_ris = (addr8 == OFF_RAW_STATUS);
  wire sel_en = (addr8 == OFF_IRQ_ENABLE);
  wire sel_ladder = (addr8 == OFF_LADDER_CTRL);
  wire sel_stat = (addr8 == OFF_OUTPUT_STATUS);
  wire sel_sense = (addr8 == OFF_SENSE_CTRL);

  // Writes to raw and output status have no decode: they fall through
  wire wr_en = reg_wr & sel_en;
  wire wr_ladder = reg_wr & sel_ladder;
  wire wr_sense = reg_wr & sel_sense;
  wire clr_raw = reg_wr & sel_mis & reg_wdata[IRQ_BIT]; // R2

  // ==========================================================
  // Interrupt status: a new event beats a clear in the same cycle
  wire masked = raw_ff & enable_ff; // R1
  assign nxt_raw = sif.event_pulse | (raw_ff & ~clr_raw); // R3 R12
  wire nxt_en = wr_en ? reg_wdata[IRQ_BIT] : enable_ff;
  assign nxt_irq = nxt_raw & nxt_en; // R4 R13

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      raw_ff <= 1'b0;
      enable_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      raw_ff <= nxt_raw; // R12
      enable_ff <= nxt_en;
      irq_ff <= nxt_irq; // R13
    end
  end

  // ==========================================================
  // Reference ladder and sense control; power resets off to save current
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      power_ff <= 1'b0; // R6
      range_ff <= 1'b0;
      tap_ff <= TAP_RESET;
    end else if (wr_ladder) begin
      power_ff <= reg_wdata[LADDER_POWER_BIT]; // R5
      range_ff <= reg_wdata[LADDER_RANGE_BIT]; // R7
      tap_ff <= reg_wdata[TAP_LSB +: TAP_W]; // R8
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sense_ff <= SENSE_LEVEL;
      level_value_ff <= 1'b0;
    end else if (wr_sense) begin
      sense_ff <= reg_wdata[SENSE_LSB +: SENSE_W]; // R11
      level_value_ff <= reg_wdata[LEVEL_VALUE_BIT];
    end
  end

  // ==========================================================
  // Read data: reserved bits read zero, unmapped reads return zero
  wire [31:0] rd_mis = {31'h0000_0000, masked}; // R1
  wire [31:0] rd_ris = {31'h0000_0000, raw_ff};
  wire [31:0] rd_en = {31'h0000_0000, enable_ff};
  wire [31:0] rd_ladder = {22'h00_0000, power_ff, range_ff, 4'h0, tap_ff};
  wire [31:0] rd_stat = {30'h0000_0000, cmp_level, 1'b0}; // R9
  wire [31:0] rd_sense = {27'h000_0000, level_value_ff, sense_ff, 2'h0};
  wire [31:0] rd_mux = sel_mis ? rd_mis :
                       sel_ris ? rd_ris :
                       sel_en ? rd_en :
                       sel_ladder ? rd_ladder :
                       sel_stat ? rd_stat :
                       sel_sense ? rd_sense : READ_ZERO;

  // Data stand for exactly one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_ff <= READ_ZERO;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : READ_ZERO;
    end
  end

  // ==========================================================
  // Outputs come straight from flops
  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;
  assign ladder_power = power_ff;
  assign ladder_range_select = range_ff;
  assign ladder_tap = tap_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_masked_read_value: assert property ( // R1
    (reg_rd && sel_mis) |=> rdata_ff[IRQ_BIT] == $past(raw_ff && enable_ff))
    else $error("masked status read does not match raw and enable");

  chk_w1c_clears_raw: assert property ( // R2
    (clr_raw && !sif.event_pulse) |=> !raw_ff && !irq_ff)
    else $error("write one did not clear the pending interrupt");

  chk_w0_keeps_raw: assert property ( // R2
    (reg_wr && sel_mis && !reg_wdata[IRQ_BIT] && raw_ff) |=> raw_ff)
    else $error("write zero cleared the pending interrupt");

  chk_event_sets_raw: assert property ( // R3
    sif.event_pulse |=> raw_ff)
    else $error("event did not set raw status");

  chk_irq_needs_enable: assert property ( // R4
    !enable_ff |-> !irq_ff)
    else $error("interrupt forwarded while disabled");

  chk_ladder_power_write: assert property ( // R5
    wr_ladder |=> ladder_power == $past(reg_wdata[LADDER_POWER_BIT]))
    else $error("ladder power did not follow write");

  chk_ladder_power_reset: assert property (@(posedge sys_clk) // R6
    $fell(reset) |-> !ladder_power)
    else $error("ladder power not off after reset");

  chk_ladder_range_write: assert property ( // R7
    wr_ladder |=> ladder_range_select == $past(reg_wdata[LADDER_RANGE_BIT]))
    else $error("ladder range did not follow write");

  chk_ladder_tap_hold: assert property ( // R8
    wr_ladder ##1 !wr_ladder [*2] |-> ladder_tap == $past(reg_wdata[TAP_LSB +: TAP_W], 2))
    else $error("tap select lost its written value");

  chk_output_level_read: assert property ( // R9
    (reg_rd && sel_stat) |=> rdata_ff[OUTPUT_LEVEL_BIT] == $past(cmp_level) && !rdata_ff[0])
    else $error("status read does not show comparator level");

  chk_level_sense_event: assert property ( // R11
    (sense_ff == SENSE_LEVEL && !wr_sense && cmp_level == level_value_ff) |=> ##1 raw_ff)
    else $error("level sense did not raise raw status");

  chk_raw_sticky_hold: assert property ( // R12
    (raw_ff && !clr_raw) |=> raw_ff)
    else $error("raw status dropped without a clear");

  chk_ro_write_ignored: assert property ( // R12
    (reg_wr && (sel_ris || sel_stat) && !sif.event_pulse) |=> raw_ff == $past(raw_ff))
    else $error("write to read-only register changed state");

  chk_irq_tracks_masked: assert property ( // R13
    irq_ff == masked)
    else $error("interrupt line differs from masked status");

  chk_read_one_cycle: assert property (
    !reg_rd |=> rdata_ff == READ_ZERO)
    else $error("read data stood outside the answer cycle");

  // ==========================================================
  // Write side: every control register follows its write and holds otherwise
  chk_enable_write: assert property ( // R4
    wr_en |=> enable_ff == $past(reg_wdata[IRQ_BIT]))
    else $error("enable did not follow write");

  chk_enable_hold: assert property ( // R4
    !wr_en |=> $stable(enable_ff))
    else $error("enable changed without a write");

  chk_ladder_hold: assert property ( // R5 R8
    !wr_ladder |=> $stable(ladder_power) && $stable(ladder_range_select) && $stable(ladder_tap))
    else $error("ladder outputs changed without a write");

  chk_ladder_tap_write: assert property ( // R8
    wr_ladder |=> ladder_tap == $past(reg_wdata[TAP_LSB +: TAP_W]))
    else $error("tap select did not follow write");

  chk_sense_write: assert property ( // R11
    wr_sense |=> sense_ff == $past(reg_wdata[SENSE_LSB +: SENSE_W])
      && level_value_ff == $past(reg_wdata[LEVEL_VALUE_BIT]))
    else $error("sense control did not follow write");

  chk_sense_hold: assert property ( // R11
    !wr_sense |=> $stable(sense_ff) && $stable(level_value_ff))
    else $error("sense control changed without a write");

  chk_ro_write_keeps: assert property ( // R12
    (reg_wr && (sel_ris || sel_stat)) |=> $stable(enable_ff) && $stable(ladder_tap))
    else $error("read-only write disturbed a control register");

  // ==========================================================
  // Read side: software sees each field in place, reserved bits as zero
  chk_raw_read_value: assert property ( // R3
    (reg_rd && sel_ris) |=> rdata_ff == {31'h0000_0000, $past(raw_ff)})
    else $error("raw status read does not match raw flag");

  chk_masked_read_reserved: assert property ( // R1
    (reg_rd && sel_mis) |=> rdata_ff[31:1] == 31'h0000_0000)
    else $error("masked status read shows reserved bits");

  chk_masked_needs_enable: assert property ( // R4
    (reg_rd && sel_mis && !enable_ff) |=> rdata_ff == READ_ZERO)
    else $error("masked status read set while disabled");

  chk_enable_read_value: assert property ( // R4
    (reg_rd && sel_en) |=> rdata_ff == {31'h0000_0000, $past(enable_ff)})
    else $error("enable read does not match enable flag");

  chk_ladder_read_value: assert property ( // R5 R7 R8
    (reg_rd && sel_ladder) |=> rdata_ff[LADDER_POWER_BIT] == $past(power_ff)
      && rdata_ff[LADDER_RANGE_BIT] == $past(range_ff)
      && rdata_ff[TAP_LSB +: TAP_W] == $past(tap_ff))
    else $error("ladder read does not match its fields");

  chk_status_reserved_zero: assert property ( // R9
    (reg_rd && sel_stat) |=> rdata_ff[31:2] == 30'h0000_0000)
    else $error("output status read shows reserved bits");

  chk_unmapped_read_zero: assert property ( // R12
    (reg_rd && !(sel_mis || sel_ris || sel_en || sel_ladder || sel_stat || sel_sense))
      |=> rdata_ff == READ_ZERO)
    else $error("unmapped read returned data");

  // ==========================================================
  // Event and interrupt path; the sync delay is left to the sync block's own check
  chk_irq_needs_raw: assert property ( // R13
    irq_ff |-> raw_ff)
    else $error("interrupt line high without raw status");

  chk_enabled_event_irq: assert property ( // R4
    (sif.event_pulse && enable_ff && !wr_en) |=> irq_ff)
    else $error("enabled event did not raise the interrupt");

  chk_disable_drops_irq: assert property ( // R4
    (wr_en && !reg_wdata[IRQ_BIT]) |=> !irq_ff)
    else $error("interrupt stayed high after disable");

  chk_irq_reset_state: assert property ( // R13
    $fell(reset) |-> !raw_ff && !irq_ff && !enable_ff)
    else $error("interrupt state not clear after reset");

  chk_level_match_event: assert property ( // R11
    (sense_ff == SENSE_LEVEL && cmp_level == level_value_ff) |=> sif.event_pulse)
    else $error("matching level gave no event");

  chk_level_mismatch_quiet: assert property ( // R11
    (sense_ff == SENSE_LEVEL && cmp_level != level_value_ff) |=> !sif.event_pulse)
    else $error("level sense fired on the other level");

  chk_edge_needs_change: assert property ( // R11
    (sense_ff != SENSE_LEVEL && $stable(cmp_level)) |=> !sif.event_pulse)
    else $error("edge sense fired on a steady level");

  chk_falling_event_raw: assert property ( // R3
    (sense_ff == SENSE_FALLING && $fell(cmp_level)) |=> ##1 raw_ff)
    else $error("falling edge did not set raw status");

  chk_rising_event_raw: assert property ( // R3
    (sense_ff == SENSE_RISING && $rose(cmp_level)) |=> ##1 raw_ff)
    else $error("rising edge did not set raw status");

  chk_either_event_raw: assert property ( // R11
    (sense_ff == SENSE_EITHER && $changed(cmp_level)) |=> ##1 raw_ff)
    else $error("either edge sense missed a change");

  cov_enabled_irq: cover property (enable_ff && sif.event_pulse ##1 irq_ff);
  cov_clear_pending: cover property (raw_ff && clr_raw ##1 !raw_ff);
  cov_set_beats_clear: cover property (clr_raw && sif.event_pulse ##1 raw_ff);
  cov_ladder_on: cover property (wr_ladder && reg_wdata[LADDER_POWER_BIT] ##1 ladder_power);
  cov_falling_event: cover property (sense_ff == SENSE_FALLING && sif.event_pulse);
endmodule // cmp_register_bank

`default_nettype wire

// ### verif/cmp_analog_model.sv
// Behavioural comparator with its resistor-ladder reference.
// Assumes the ladder controls come from the register bank; test voltage from the bench.
`timescale 1ns/1ps
`default_nettype none

module cmp_analog_model
  import cmp_regs_pkg::*;
#(
  parameter int AVDD_MV = 3300
) (
  input wire logic ladder_power,
  input wire logic ladder_range_select,
  input wire logic [TAP_W-1:0] ladder_tap,
  input wire logic [15:0] test_mv,
  output logic comparator_out
);
  int ref_mv;

  // ==========================================================
  // Reference voltage; integer millivolts are coarse but ample here
  always_comb begin
    if (!ladder_power) begin
      ref_mv = 0;
    end else if (ladder_range_select) begin
      ref_mv = AVDD_MV * int'(ladder_tap) / 24;
    end else begin
      ref_mv = AVDD_MV * (int'(ladder_tap) + 8) / 32;
    end
  end

  // No hysteresis: a test voltage equal to the reference reads low
  assign comparator_out = (int'(test_mv) > ref_mv);
endmodule // cmp_analog_model

`default_nettype wire

// ### verif/test_cmp_register_bank.sv
// Self-checking bench for the comparator register bank.
// Assumes the strobe register port and a behavioural comparator on the far side.
`timescale 1ns/1ps
`default_nettype none

`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module test_cmp_register_bank;
  import cmp_regs_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic comparator_out;
  logic irq;
  logic ladder_power;
  logic ladder_range_select;
  logic [TAP_W-1:0] ladder_tap;
  logic [15:0] test_mv = 16'h0000;
  logic [31:0] d;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // Ladder settings and expected comparator level at the fixed 1000 mV test voltage
  logic [31:0] lad_val [4] = '{32'h0000_0000, 32'h0000_0204, 32'h0000_0304, 32'h0000_030C};
  logic lad_out [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  // Sense settings: level-high, falling, rising, either edge
  logic [31:0] sense_cfg [4] = '{32'h0000_0010, 32'h0000_0004, 32'h0000_0008, 32'h0000_000C};
  logic rise_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic fall_exp [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

  always #5 sys_clk = ~sys_clk;

  cmp_register_bank cmp_register_bank_inst (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comparator_out(comparator_out),
    .irq(irq), .ladder_power(ladder_power), .ladder_range_select(ladder_range_select),
    .ladder_tap(ladder_tap)
  );

  cmp_analog_model cmp_analog_model_inst (
    .ladder_power(ladder_power), .ladder_range_select(ladder_range_select),
    .ladder_tap(ladder_tap), .test_mv(test_mv), .comparator_out(comparator_out)
  );

  // ==========================================================
  // Bus tasks; each returns 1 ns after an edge so checks see settled values
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic print_verdict;
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      print_verdict();
    end
  end

  // ==========================================================
  // Main sequence; all writes to mapped registers keep reserved bits at zero
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHECK("ladder_power", 1'b0, ladder_power)
    rd(OFF_LADDER_CTRL, d); `CHECK("ladder reset", 32'h0000_0000, d)
    rd(OFF_IRQ_ENABLE, d); `CHECK("enable reset", 32'h0000_0000, d)
    rd(OFF_RAW_STATUS, d); `CHECK("raw level low", 32'h0000_0001, d)
    rd(OFF_MASKED_STATUS, d); `CHECK("masked disabled", 32'h0000_0000, d)
    `CHECK("irq disabled", 1'b0, irq)

    // Ladder settings seen at the pins and through the comparator
    for (int i = 0; i < 4; i++) begin
      test_mv <= 16'h03E8;
      wr(OFF_LADDER_CTRL, lad_val[i]);
      `CHECK("ladder_power", lad_val[i][9], ladder_power)
      `CHECK("ladder_range", lad_val[i][8], ladder_range_select)
      `CHECK("ladder_tap", lad_val[i][3:0], ladder_tap)
      rd(OFF_LADDER_CTRL, d); `CHECK("ladder readback", lad_val[i], d)
      repeat (8) @(posedge sys_clk);
      rd(OFF_OUTPUT_STATUS, d); `CHECK("output level", {30'h0, lad_out[i], 1'b0}, d)
    end

    // Every sense mode with the interrupt disabled
    for (int i = 0; i < 4; i++) begin
      test_mv <= 16'h03E8;
      wr(OFF_SENSE_CTRL, sense_cfg[i]);
      rd(OFF_SENSE_CTRL, d); `CHECK("sense readback", sense_cfg[i], d)
      repeat (8) @(posedge sys_clk);
      wr(OFF_MASKED_STATUS, 32'h0000_0001);
      rd(OFF_RAW_STATUS, d); `CHECK("raw cleared", 32'h0000_0000, d)
      test_mv <= 16'h07D0;
      repeat (8) @(posedge sys_clk);
      rd(OFF_RAW_STATUS, d); `CHECK("raw after rise", {31'h0, rise_exp[i]}, d)
      rd(OFF_MASKED_STATUS, d); `CHECK("masked off", 32'h0000_0000, d)
      `CHECK("irq off", 1'b0, irq)
      wr(OFF_MASKED_STATUS, 32'h0000_0001);
      test_mv <= 16'h03E8;
      repeat (8) @(posedge sys_clk);
      rd(OFF_RAW_STATUS, d); `CHECK("raw after fall", {31'h0, fall_exp[i]}, d)
    end

    // Pending either-edge event, then enable, mask and clear
    wr(OFF_IRQ_ENABLE, 32'h0000_0001);
    rd(OFF_IRQ_ENABLE, d); `CHECK("enable readback", 32'h0000_0001, d)
    rd(OFF_MASKED_STATUS, d); `CHECK("masked on", 32'h0000_0001, d)
    `CHECK("irq on", 1'b1, irq)
    wr(OFF_RAW_STATUS, 32'h0000_0000);
    rd(OFF_RAW_STATUS, d); `CHECK("raw write ignored", 32'h0000_0001, d)
    wr(OFF_MASKED_STATUS, 32'h0000_0000);
    rd(OFF_MASKED_STATUS, d); `CHECK("zero no clear", 32'h0000_0001, d)
    wr(OFF_IRQ_ENABLE, 32'h0000_0000);
    `CHECK("irq masked", 1'b0, irq)
    rd(OFF_RAW_STATUS, d); `CHECK("raw kept", 32'h0000_0001, d)
    wr(OFF_IRQ_ENABLE, 32'h0000_0001);
    wr(OFF_MASKED_STATUS, 32'h0000_0001);
    `CHECK("irq cleared", 1'b0, irq)
    rd(OFF_RAW_STATUS, d); `CHECK("raw w1c", 32'h0000_0000, d)
    test_mv <= 16'h07D0;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHECK("irq event", 1'b1, irq)
    rd(OFF_MASKED_STATUS, d); `CHECK("masked event", 32'h0000_0001, d)

    // Unmapped place and read-only status leave the ladder alone
    wr(8'h14, 32'h0000_0001);
    wr(OFF_OUTPUT_STATUS, 32'h0000_0000);
    rd(8'h14, d); `CHECK("unmapped", 32'h0000_0000, d)
    rd(OFF_LADDER_CTRL, d); `CHECK("ladder kept", 32'h0000_030C, d)
    print_verdict();
  end
endmodule // test_cmp_register_bank

`default_nettype wire
